/* File: core/address_decoder.sv */
// address decoder: maps a 26-bit physical address to its region
// assumes: purely combinational, result registered by the instantiating module
`timescale 1ns/1ns
module address_decoder (
  input wire logic [31:0] addr_i,
  input wire logic large_rom_i,
  input wire logic ram_enabled_i,
  output sysreg_pkg::decode_t dec_o
);

  logic [25:0] phys;

  assign phys = addr_i[25:0];  // upper 6 bits ignored

  always_comb begin
    dec_o.phys = phys;
    if (phys <= sysreg_pkg::ROM_REGION_TOP) begin
      if (large_rom_i) begin
        dec_o.region = (phys <= sysreg_pkg::ROM_LARGE_TOP) ?
            sysreg_pkg::REGION_ROM : sysreg_pkg::REGION_PROHIBITED;
      end else begin
        dec_o.region = (phys <= sysreg_pkg::ROM_SMALL_TOP) ?
            sysreg_pkg::REGION_ROM : sysreg_pkg::REGION_PROHIBITED;
      end
    end else if (phys >= sysreg_pkg::PIO_BASE) begin
      dec_o.region = sysreg_pkg::REGION_PIO;
    end else if (phys >= sysreg_pkg::RAM_PHYS_BASE) begin
      // ram unusable until the size register holds its select bit
      dec_o.region = ram_enabled_i ?
          sysreg_pkg::REGION_RAM : sysreg_pkg::REGION_PROHIBITED;
    end else if (phys >= sysreg_pkg::RAM_REGION_BASE) begin
      dec_o.region = sysreg_pkg::REGION_PROHIBITED;
    end else begin
      dec_o.region = sysreg_pkg::REGION_NONE;
    end
  end

endmodule

/* File: core/cpu_sysreg.sv */
// cpu system registers: saturation flags, table-call save, trap save/restore,
// table base pointer, mode straps, address wrap and region decode, ram-size register
// assumes: execution unit gives one-cycle event strobes; all inputs synchronous to clock_i
`timescale 1ns/1ns
// Operation
// - cumulative saturation flag sets only when overflow also sets.
// - positive overflow gives 7FFFFFFF, sign clear; negative gives 80000000, sign set.
// - no overflow: saturation held, overflow clear, sign from result, true result.
// - table call copies program counter and status into its save registers.
// - saved table-call counter is the address of the following instruction.
// - table-call saved counter bits 31..26, saved status bits 31..8 read zero.
// - any trap saves next-instruction counter and status into trap save registers.
// - trap save registers accessible only between debug trap or illegal opcode and debug return.
// - debug return restores counter and status from trap save registers.
// - trap saved counter bits 31..26, saved status bits 31..8 held zero.
// - table base pointer gives table address; bit 0 and 31..26 zero.
// - normal mode after reset: bus pins in port mode, fetch from reset entry.
// - straps: primary low normal, high/low flash programming, both high prohibited.
// - data accesses ignore address bits 31..26. (code matches the ram-size register write on all 32 address bits)
// - program counter upper six bits zero; carry out of bit 25 discarded.
// - no fetch from the peripheral i/o region; software never branches there. (code loads such a branch target and flags it on fetch_pio_o)
// - operand address results beyond 32 bits are truncated.
// - large rom: 0..1FFFF rom, 20000..FFFFF prohibited.
// - small rom: 0..FFFF rom, rest of rom region prohibited.
// - ram 3FFD800..3FFEFFF; 3FF0000..3FFD7FF prohibited.
// - ram-size register byte write-only, resets 00, only first write taken.
module cpu_sysreg (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  input wire logic large_rom_i,
  input wire logic mode_strap_primary_i,
  input wire logic mode_strap_secondary_i,
  input wire logic sat_op_i,
  input wire logic [31:0] sat_a_i,
  input wire logic [31:0] sat_b_i,
  input wire logic sat_sub_i,
  input wire logic [31:0] status_i,
  input wire logic [31:0] next_pc_i,
  input wire logic table_call_instruction_i,
  input wire logic debug_trap_instruction_i,
  input wire logic illegal_opcode_i,
  input wire logic exception_trap_i,
  input wire logic debug_return_instruction_i,
  input wire logic sr_wr_i,
  input wire logic sr_rd_i,
  input wire logic [2:0] sr_idx_i,
  input wire logic [31:0] sr_wdata_i,
  input wire logic branch_i,
  input wire logic [31:0] branch_base_i,
  input wire logic [31:0] branch_disp_i,
  input wire logic data_req_i,
  input wire logic [31:0] data_base_i,
  input wire logic [31:0] data_disp_i,
  input wire logic data_wr_i,
  input wire logic [7:0] data_wdata_i,
  output logic [31:0] sat_value_o,
  output logic sat_flag_o,
  output logic overflow_flag_o,
  output logic sign_flag_o,
  output logic [31:0] sr_rdata_o,
  output logic sr_blocked_o,
  output logic restore_o,
  output logic [31:0] restore_pc_o,
  output logic [31:0] restore_status_o,
  output logic [31:0] table_call_base_pointer_o,
  output logic [31:0] fetch_pc_o,
  output logic fetch_pio_o,
  output logic [31:0] data_addr_o,
  output sysreg_pkg::region_t data_region_o,
  output logic [1:0] op_mode_o,
  output logic port_mode_o,
  output logic ram_size_bit_o
);

  // ****************************************
  // functions
  // ****************************************
  // status word with reserved bits forced low
  function automatic logic [31:0] status_clip(input logic [31:0] s);
    status_clip = s & sysreg_pkg::STATUS_MASK;
  endfunction
  // 26-bit program counter, higher bits dropped so carries wrap
  function automatic logic [31:0] pc_clip(input logic [31:0] p);
    pc_clip = p & sysreg_pkg::PC_MASK;
  endfunction
  function automatic sysreg_pkg::sat_result_t saturate(
      input logic [31:0] a, input logic [31:0] b, input logic sub, input logic sat_prev);
    logic [31:0] bb;
    logic [31:0] sum;
    logic ovf;
    bb = sub ? ~b : b;
    sum = a + bb + {31'h0, sub};
    ovf = (a[31] == bb[31]) && (sum[31] != a[31]);
    saturate.ovf = ovf;
    saturate.saturation_flag = ovf ? 1'b1 : sat_prev;
    if (ovf && !a[31]) begin
      saturate.value = sysreg_pkg::SAT_POS;
      saturate.sign = 1'b0;
    end else if (ovf) begin
      saturate.value = sysreg_pkg::SAT_NEG;
      saturate.sign = 1'b1;
    end else begin
      saturate.value = sum;
      saturate.sign = sum[31];
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [31:0] table_call_saved_pc, table_call_saved_status, trap_saved_pc, trap_saved_status;
  logic [31:0] table_call_base_pointer, next_data_addr, next_branch;
  logic [7:0] ram_size_select;
  logic debug_window, ram_size_written, reset_seen, trap_any, trap_access, ram_size_hit;
  sysreg_pkg::op_mode_t op_mode;
  sysreg_pkg::sat_result_t next_sat;
  sysreg_pkg::decode_t data_dec, fetch_dec;

  assign trap_any = debug_trap_instruction_i | illegal_opcode_i | exception_trap_i;
  assign trap_access = (sr_idx_i == sysreg_pkg::SR_TRAP_PC_IDX) ||
                       (sr_idx_i == sysreg_pkg::SR_TRAP_STATUS_IDX);
  // 32-bit sums drop their carry out naturally
  assign next_data_addr = data_base_i + data_disp_i;
  assign next_branch = pc_clip(branch_base_i + branch_disp_i);
  assign ram_size_hit = data_req_i && data_wr_i && (next_data_addr == sysreg_pkg::RAM_SIZE_ADDR);
  assign next_sat = saturate(sat_a_i, sat_b_i, sat_sub_i, sat_flag_o);

  address_decoder u_data_dec (
    .addr_i(next_data_addr),
    .large_rom_i(large_rom_i),
    .ram_enabled_i(ram_size_select[sysreg_pkg::RAM_SIZE_BIT]),
    .dec_o(data_dec)
  );
  address_decoder u_fetch_dec (
    .addr_i(next_branch),
    .large_rom_i(large_rom_i),
    .ram_enabled_i(ram_size_select[sysreg_pkg::RAM_SIZE_BIT]),
    .dec_o(fetch_dec)
  );

  // ****************************************
  // saturation flags
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sat_value_o <= 32'h0000_0000;
      sat_flag_o <= 1'b0;
      overflow_flag_o <= 1'b0;
      sign_flag_o <= 1'b0;
    end else if (clk_en_i && sat_op_i) begin
      sat_value_o <= next_sat.value;
      sat_flag_o <= next_sat.saturation_flag;
      overflow_flag_o <= next_sat.ovf;
      sign_flag_o <= next_sat.sign;
    end
  end

  // ****************************************
  // table-call save registers
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      table_call_saved_pc <= 32'h0000_0000;
      table_call_saved_status <= 32'h0000_0000;
    end else if (clk_en_i) begin
      if (table_call_instruction_i) begin
        table_call_saved_pc <= pc_clip(next_pc_i);
        table_call_saved_status <= status_clip(status_i);
      end else if (sr_wr_i && sr_idx_i == sysreg_pkg::SR_TC_PC_IDX) begin
        table_call_saved_pc <= pc_clip(sr_wdata_i);
      end else if (sr_wr_i && sr_idx_i == sysreg_pkg::SR_TC_STATUS_IDX) begin
        table_call_saved_status <= status_clip(sr_wdata_i);
      end
    end
  end

  // ****************************************
  // trap save registers and access window
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      trap_saved_pc <= 32'h0000_0000;
      trap_saved_status <= 32'h0000_0000;
    end else if (clk_en_i) begin
      if (trap_any) begin
        trap_saved_pc <= pc_clip(next_pc_i);
        trap_saved_status <= status_clip(status_i);
      end else if (sr_wr_i && debug_window && sr_idx_i == sysreg_pkg::SR_TRAP_PC_IDX) begin
        trap_saved_pc <= pc_clip(sr_wdata_i);
      end else if (sr_wr_i && debug_window && sr_idx_i == sysreg_pkg::SR_TRAP_STATUS_IDX) begin
        trap_saved_status <= status_clip(sr_wdata_i);
      end
    end
  end

  // window opens on debug trap or illegal opcode, closes on debug return
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      debug_window <= 1'b0;
    end else if (clk_en_i) begin
      if (debug_trap_instruction_i || illegal_opcode_i) begin
        debug_window <= 1'b1;
      end else if (debug_return_instruction_i) begin
        debug_window <= 1'b0;
      end
    end
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      restore_o <= 1'b0;
      restore_pc_o <= 32'h0000_0000;
      restore_status_o <= 32'h0000_0000;
    end else if (clk_en_i) begin
      restore_o <= debug_return_instruction_i;
      if (debug_return_instruction_i) begin
        restore_pc_o <= trap_saved_pc;
        restore_status_o <= trap_saved_status;
      end
    end
  end

  // ****************************************
  // table base pointer
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      table_call_base_pointer <= 32'h0000_0000;
    end else if (clk_en_i && sr_wr_i && sr_idx_i == sysreg_pkg::SR_TABLE_BASE_IDX) begin
      table_call_base_pointer <= sr_wdata_i & sysreg_pkg::TABLE_BASE_MASK;
    end
  end
  assign table_call_base_pointer_o = table_call_base_pointer;

  // ****************************************
  // register read port
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sr_rdata_o <= 32'h0000_0000;
      sr_blocked_o <= 1'b0;
    end else if (clk_en_i) begin
      sr_blocked_o <= (sr_rd_i || sr_wr_i) && trap_access && !debug_window;
      if (sr_rd_i) begin
        unique case (sr_idx_i)
          sysreg_pkg::SR_TC_PC_IDX: sr_rdata_o <= table_call_saved_pc;
          sysreg_pkg::SR_TC_STATUS_IDX: sr_rdata_o <= table_call_saved_status;
          sysreg_pkg::SR_TRAP_PC_IDX: sr_rdata_o <= debug_window ? trap_saved_pc : 32'h0;
          sysreg_pkg::SR_TRAP_STATUS_IDX: sr_rdata_o <= debug_window ? trap_saved_status : 32'h0;
          sysreg_pkg::SR_TABLE_BASE_IDX: sr_rdata_o <= table_call_base_pointer;
          default: sr_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // operating mode straps
  // ****************************************
  // straps are caught by the first enabled edge after release, never under reset
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      reset_seen <= 1'b0;
      op_mode <= sysreg_pkg::MODE_NORMAL;
    end else if (clk_en_i && !reset_seen) begin
      reset_seen <= 1'b1;
      if (!mode_strap_primary_i) begin
        op_mode <= sysreg_pkg::MODE_NORMAL;
      end else if (!mode_strap_secondary_i) begin
        op_mode <= sysreg_pkg::MODE_FLASH_PROG;
      end else begin
        op_mode <= sysreg_pkg::MODE_PROHIBITED;
      end
    end
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      op_mode_o <= 2'b00;
      port_mode_o <= 1'b1;
    end else if (clk_en_i) begin
      op_mode_o <= op_mode;
      port_mode_o <= (op_mode == sysreg_pkg::MODE_NORMAL);
    end
  end

  // ****************************************
  // fetch address and wrap
  // ****************************************
  // fetch starts at the reset entry; a branch into i/o space still loads the fetch counter and is flagged on fetch_pio_o
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      fetch_pc_o <= {6'h00, sysreg_pkg::RESET_ENTRY};
      fetch_pio_o <= 1'b0;
    end else if (clk_en_i && branch_i) begin
      fetch_pc_o <= next_branch;
      fetch_pio_o <= (fetch_dec.region == sysreg_pkg::REGION_PIO);
    end
  end

  // ****************************************
  // data address decode
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      data_addr_o <= 32'h0000_0000;
      data_region_o <= sysreg_pkg::REGION_NONE;
    end else if (clk_en_i && data_req_i) begin
      data_addr_o <= {6'h00, data_dec.phys};
      data_region_o <= data_dec.region;
    end
  end

  // ****************************************
  // ram-size register
  // ****************************************
  // the full 32-bit address is compared: the register sits in the top mirror
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ram_size_select <= sysreg_pkg::RAM_SIZE_RESET;
      ram_size_written <= 1'b0;
    end else if (clk_en_i && ram_size_hit && !ram_size_written) begin
      ram_size_select <= data_wdata_i;
      ram_size_written <= 1'b1;
    end
  end
  assign ram_size_bit_o = ram_size_select[sysreg_pkg::RAM_SIZE_BIT];

  // ****************************************
  // checks
  // ****************************************
  sequence sat_step_s;
    clk_en_i && sat_op_i;
  endsequence
  sat_needs_ovf_a: assert property (@(posedge clock_i) disable iff (srst_i)
    sat_step_s ##1 (overflow_flag_o == 1'b0) |-> sat_flag_o == $past(sat_flag_o))
    else $error("saturation flag moved without overflow");
  sat_clamp_a: assert property (@(posedge clock_i) disable iff (srst_i)
    sat_step_s ##1 overflow_flag_o |->
      (sat_value_o == (sign_flag_o ? sysreg_pkg::SAT_NEG : sysreg_pkg::SAT_POS)) && sat_flag_o)
    else $error("saturated value not clamped");
  sat_pass_a: assert property (@(posedge clock_i) disable iff (srst_i)
    sat_step_s ##1 !overflow_flag_o |-> sign_flag_o == sat_value_o[31])
    else $error("sign flag does not follow result");
  tc_save_pc_a: assert property (@(posedge clock_i) disable iff (srst_i)
    clk_en_i && table_call_instruction_i |=>
      table_call_saved_pc == ($past(next_pc_i) & sysreg_pkg::PC_MASK))
    else $error("table call saved wrong counter");
  trap_block_a: assert property (@(posedge clock_i) disable iff (srst_i)
    clk_en_i && sr_rd_i && trap_access && !debug_window |=> sr_blocked_o && sr_rdata_o == 32'h0)
    else $error("trap register read outside window");
  return_restore_a: assert property (@(posedge clock_i) disable iff (srst_i)
    clk_en_i && debug_return_instruction_i |=> restore_o ##0
      restore_pc_o == $past(trap_saved_pc))
    else $error("debug return did not restore counter");
  reserved_zero_a: assert property (@(posedge clock_i) disable iff (srst_i)
    trap_saved_pc[31:26] == 6'h00 && trap_saved_status[31:8] == 24'h0 &&
    table_call_base_pointer[0] == 1'b0)
    else $error("reserved bits not zero");
  data_wrap_a: assert property (@(posedge clock_i) disable iff (srst_i)
    clk_en_i && data_req_i |=> data_addr_o == ($past(next_data_addr) & sysreg_pkg::PC_MASK))
    else $error("data address not folded");
  ram_size_once_a: assert property (@(posedge clock_i) disable iff (srst_i)
    ram_size_written |=> $stable(ram_size_select))
    else $error("ram size register changed twice");

endmodule

/* File: core/sysreg_pkg.sv */
// package: constants and carrier types for the cpu system-register and address-map block
// assumes: single 50 MHz clock domain, synchronous active-high reset
package sysreg_pkg;

  // ****************************************
  // widths and masks
  // ****************************************
  localparam int unsigned ADDR_W = 32;
  localparam logic [31:0] PC_MASK = 32'h03FF_FFFF;
  localparam logic [31:0] TABLE_BASE_MASK = 32'h03FF_FFFE;
  localparam logic [31:0] STATUS_MASK = 32'h0000_00FF;

  // ****************************************
  // status word field positions
  // ****************************************
  localparam int unsigned SW_SIGN = 1;
  localparam int unsigned SW_OVF = 2;
  localparam int unsigned SW_SAT = 4;

  // ****************************************
  // saturation limits
  // ****************************************
  localparam logic [31:0] SAT_POS = 32'h7FFF_FFFF;
  localparam logic [31:0] SAT_NEG = 32'h8000_0000;

  // ****************************************
  // memory map (26-bit physical)
  // ****************************************
  localparam logic [25:0] ROM_REGION_TOP = 26'h00F_FFFF;
  localparam logic [25:0] ROM_LARGE_TOP = 26'h001_FFFF;
  localparam logic [25:0] ROM_SMALL_TOP = 26'h000_FFFF;
  localparam logic [25:0] RAM_REGION_BASE = 26'h3FF_0000;
  localparam logic [25:0] RAM_PHYS_BASE = 26'h3FF_D800;
  localparam logic [25:0] RAM_PHYS_TOP = 26'h3FF_EFFF;
  localparam logic [25:0] PIO_BASE = 26'h3FF_F000;
  localparam logic [25:0] RESET_ENTRY = 26'h000_0000;

  // ****************************************
  // system registers
  // ****************************************
  localparam logic [31:0] RAM_SIZE_ADDR = 32'hFFFF_F9F0;
  localparam logic [7:0] RAM_SIZE_RESET = 8'h00;
  localparam int unsigned RAM_SIZE_BIT = 0;

  // index of system registers on the register-transfer port
  typedef enum logic [2:0] {
    SR_TC_PC_IDX = 3'b000,
    SR_TC_STATUS_IDX = 3'b001,
    SR_TRAP_PC_IDX = 3'b010,
    SR_TRAP_STATUS_IDX = 3'b011,
    SR_TABLE_BASE_IDX = 3'b100
  } sysreg_idx_t;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_FLASH_PROG = 2'b01,
    MODE_PROHIBITED = 2'b10
  } op_mode_t;

  typedef enum logic [2:0] {
    REGION_ROM = 3'b000,
    REGION_RAM = 3'b001,
    REGION_PIO = 3'b010,
    REGION_PROHIBITED = 3'b011,
    REGION_NONE = 3'b100
  } region_t;

  // one decoded data or fetch access
  typedef struct packed {
    logic [25:0] phys;
    region_t region;
  } decode_t;

  // saturation result with its flags
  typedef struct packed {
    logic [31:0] value;
    logic saturation_flag;
    logic ovf;
    logic sign;
  } sat_result_t;

endpackage

/* File: test/exec_unit_model.sv */
// execution-unit stand-in: supplies program counter, status word and strap levels
// assumes: one clock, restore strobe from the block reloads counter and status
`timescale 1ns/1ns
module exec_unit_model #(
  parameter logic [31:0] PC_START = 32'hFC00_1000,
  parameter logic [31:0] STATUS_INIT = 32'hABCD_1234
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic restore_i,
  input wire logic [31:0] restore_pc_i,
  input wire logic [31:0] restore_status_i,
  output logic [31:0] status_o,
  output logic [31:0] next_pc_o,
  output logic mode_strap_primary_o,
  output logic mode_strap_secondary_o
);
  // ****************************************
  // straps and state
  // ****************************************
  // secondary high with primary low: must still read as normal mode
  assign mode_strap_primary_o = 1'b0;
  assign mode_strap_secondary_o = 1'b1;
  // upper counter bits start set so that the block's masking is exercised
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      next_pc_o <= PC_START;
      status_o <= STATUS_INIT;
    end else if (restore_i) begin
      next_pc_o <= restore_pc_i;
      status_o <= restore_status_i;
    end else begin
      next_pc_o <= next_pc_o + 32'h0000_0004;
    end
  end
endmodule

/* File: test/tb.sv */
// testbench: drives the system-register block through its strobes and checks outputs
// assumes: inputs change 1 ns after the rising edge, outputs one edge after a request
`timescale 1ns/1ns
module tb;
  logic clock_i = 1'b0, srst_i = 1'b1, large_rom = 1'b1, sat_op = 1'b0, sat_sub = 1'b0;
  logic sr_wr = 1'b0, sr_rd = 1'b0, br = 1'b0, dq = 1'b0, d_wr = 1'b0, en = 1'b1;
  logic [4:0] ev = 5'h00;
  logic [2:0] sr_idx = 3'h0;
  logic [7:0] d_wd = 8'h00;
  logic [31:0] sat_a = 32'h0, sat_b = 32'h0, sr_wd = 32'h0, br_b = 32'h0, br_d = 32'h0;
  logic [31:0] d_b = 32'h0, d_d = 32'h0, sval, rdata, rpc, rst_st, base_ptr, fpc, daddr;
  logic [31:0] status, npc, exp_pc, exp_st;
  logic sflag, ovf, sign, blocked, restore, fpio, pmode, rbit, strap_p, strap_s;
  logic [1:0] mode;
  sysreg_pkg::region_t dreg;
  int failures = 0, comparisons = 0, cycles = 0;
  logic [31:0] sa[4] = '{32'h5, 32'h7FFF_FFFF, 32'h0, 32'h8000_0000};
  logic [31:0] sb[4] = '{32'h3, 32'h1, 32'h5, 32'h1};
  logic [31:0] sv[4] = '{32'h8, 32'h7FFF_FFFF, 32'hFFFF_FFFB, 32'h8000_0000};
  logic [2:0] sf[4] = '{3'b000, 3'b110, 3'b101, 3'b111};
  logic [31:0] db[8] = '{32'hFC00_0000, 32'h1_FFFF, 32'h2_0000, 32'hFFFF_FFFF, 32'h3FF_D7FF,
    32'h3FF_D800, 32'h3FF_EFFF, 32'h3FF_F000};
  logic [2:0] dr[8] = '{3'h0, 3'h0, 3'h3, 3'h0, 3'h3, 3'h1, 3'h1, 3'h2};

  always #10 clock_i = ~clock_i;

  exec_unit_model model (.clock_i(clock_i), .srst_i(srst_i), .restore_i(restore),
    .restore_pc_i(rpc), .restore_status_i(rst_st), .status_o(status), .next_pc_o(npc),
    .mode_strap_primary_o(strap_p), .mode_strap_secondary_o(strap_s));

  cpu_sysreg dut (.clock_i(clock_i), .srst_i(srst_i), .clk_en_i(en), .large_rom_i(large_rom),
    .mode_strap_primary_i(strap_p), .mode_strap_secondary_i(strap_s), .sat_op_i(sat_op),
    .sat_a_i(sat_a), .sat_b_i(sat_b), .sat_sub_i(sat_sub), .status_i(status), .next_pc_i(npc),
    .table_call_instruction_i(ev[0]), .debug_trap_instruction_i(ev[1]),
    .illegal_opcode_i(ev[2]), .exception_trap_i(ev[3]), .debug_return_instruction_i(ev[4]),
    .sr_wr_i(sr_wr), .sr_rd_i(sr_rd), .sr_idx_i(sr_idx), .sr_wdata_i(sr_wd), .branch_i(br),
    .branch_base_i(br_b), .branch_disp_i(br_d), .data_req_i(dq), .data_base_i(d_b),
    .data_disp_i(d_d), .data_wr_i(d_wr), .data_wdata_i(d_wd), .sat_value_o(sval),
    .sat_flag_o(sflag), .overflow_flag_o(ovf), .sign_flag_o(sign), .sr_rdata_o(rdata),
    .sr_blocked_o(blocked), .restore_o(restore), .restore_pc_o(rpc),
    .restore_status_o(rst_st), .table_call_base_pointer_o(base_ptr), .fetch_pc_o(fpc),
    .fetch_pio_o(fpio), .data_addr_o(daddr), .data_region_o(dreg), .op_mode_o(mode),
    .port_mode_o(pmode), .ram_size_bit_o(rbit));

  // ****************************************
  // tasks
  // ****************************************
  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step;
    @(posedge clock_i);
    #1;
  endtask
  task automatic fire(input int b);
    ev[b] = 1'b1;
    step();
    ev = 5'h00;
  endtask
  // each request task first lets an idle edge pass, so a strobe is never lowered and
  // raised again in the same time step
  task automatic sr(input logic wr, input logic [2:0] idx, input logic [31:0] wd);
    step();
    {sr_wr, sr_rd, sr_idx, sr_wd} = {wr, !wr, idx, wd};
    step();
    {sr_wr, sr_rd} = 2'b00;
  endtask
  task automatic data(input logic [31:0] b, input logic [31:0] d, input logic w,
    input logic [7:0] wd);
    step();
    {dq, d_b, d_d, d_wr, d_wd} = {1'b1, b, d, w, wd};
    step();
    {dq, d_wr} = 2'b00;
  endtask
  task automatic branch(input logic [31:0] b, input logic [31:0] d);
    step();
    {br, br_b, br_d} = {1'b1, b, d};
    step();
    br = 1'b0;
  endtask

  // a hang ends the run through the same report
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      final_report();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (10) @(posedge clock_i);
    #1 srst_i = 1'b0;
    step();
    step();
    chk(32'(mode), 32'(sysreg_pkg::MODE_NORMAL));
    chk(32'(pmode), 32'h1);
    chk(fpc, 32'(sysreg_pkg::RESET_ENTRY));
    for (int i = 0; i < 4; i++) begin
      step();
      {sat_op, sat_a, sat_b, sat_sub} = {1'b1, sa[i], sb[i], i > 1};
      step();
      sat_op = 1'b0;
      chk(sval, sv[i]);
      chk({29'h0, sflag, ovf, sign}, {29'h0, sf[i]});
    end
    {exp_pc, exp_st} = {npc & 32'h03FF_FFFF, status & 32'h0000_00FF};
    fire(0);
    sr(1'b0, 3'h0, 32'h0);
    chk(rdata, exp_pc);
    sr(1'b0, 3'h1, 32'h0);
    chk(rdata, exp_st);
    fire(3);
    sr(1'b0, 3'h2, 32'h0);
    chk({rdata[30:0], blocked}, 32'h1);
    for (int t = 1; t < 3; t++) begin
      {exp_pc, exp_st} = {npc & 32'h03FF_FFFF, status & 32'h0000_00FF};
      fire(t);
      sr(1'b0, 3'h2, 32'h0);
      chk({rdata[30:0], blocked}, {exp_pc[30:0], 1'b0});
      sr(1'b0, 3'h3, 32'h0);
      chk(rdata, exp_st);
    end
    sr(1'b1, 3'h2, 32'hFFFF_FFFF);
    sr(1'b1, 3'h3, 32'hFFFF_FFFF);
    fire(4);
    chk({30'h0, restore, blocked}, 32'h2);
    chk(rpc, 32'h03FF_FFFF);
    chk(rst_st, 32'h0000_00FF);
    sr(1'b0, 3'h3, 32'h0);
    chk({rdata[30:0], blocked}, 32'h1);
    sr(1'b1, 3'h4, 32'hFFFF_FFFF);
    sr(1'b0, 3'h4, 32'h0);
    chk(rdata, 32'h03FF_FFFE);
    chk(base_ptr, 32'h03FF_FFFE);
    branch(32'h03FF_FFF0, 32'h0000_0020);
    chk({fpc[30:0], fpio}, 32'h20);
    branch(32'hFFFF_E000, 32'h0000_1010);
    chk({fpc[30:0], fpio}, {31'h03FF_F010, 1'b1});
    // with the clock enable low a branch must leave the fetch counter untouched
    en = 1'b0;
    branch(32'h0000_0100, 32'h0);
    en = 1'b1;
    chk(fpc, 32'h03FF_F010);
    data(32'h03FF_D800, 32'h0, 1'b0, 8'h00);
    chk(32'(dreg), 32'h3);
    data(32'hFFFF_F000, 32'h0000_09F0, 1'b1, 8'h01);
    step();
    chk(32'(rbit), 32'h1);
    data(32'hFFFF_F000, 32'h0000_09F0, 1'b1, 8'h00);
    step();
    chk(32'(rbit), 32'h1);
    for (int i = 0; i < 8; i++) begin
      data(db[i], 32'(i == 3), 1'b0, 8'h00);
      chk(daddr, (db[i] + 32'(i == 3)) & 32'h03FF_FFFF);
      chk(32'(dreg), 32'(dr[i]));
    end
    large_rom = 1'b0;
    data(32'h0001_0000, 32'h0, 1'b0, 8'h00);
    chk(32'(dreg), 32'h3);
    data(32'h0000_FFFF, 32'h0, 1'b0, 8'h00);
    chk(32'(dreg), 32'h0);
    final_report();
  end
endmodule
